/* File: rtl/ddo_defs.svh */
// Constants for the sample output port: register map, field positions,
// reset values and counts. Included by every design file of the block.
`ifndef DDO_DEFS_SVH
`define DDO_DEFS_SVH
`define DDO_OFF_CTRL  5'h00
`define DDO_OFF_DIV   5'h04
`define DDO_OFF_STAT  5'h08
`define DDO_OFF_MASK  5'h0c
`define DDO_OFF_INFO  5'h10
`define DDO_CTRL_W    15
`define DDO_CTRL_RST  15'h0000
`define DDO_DIV_RST   8'h04
`define DDO_C_SOE     0
`define DDO_C_SCKP    1
`define DDO_C_FSP     2
`define DDO_C_RDYP    3
`define DDO_C_PACK    4
`define DDO_C_DBG     5
`define DDO_C_CM      6
`define DDO_C_SLVP    7
`define DDO_C_RATE    11:8
`define DDO_C_CSEL    14:12
`define DDO_EV_W      4
`define DDO_S_OSP     0
`define DDO_S_OVR     1
`define DDO_S_FLUSH   2
`define DDO_S_CHAIN   3
`define DDO_SER_BITS  6'd32
`define DDO_HALF_BITS 6'd16
`define DDO_RX_BITS   5'd16
`define DDO_W_AI      3'd0
`define DDO_W_AQ      3'd1
`define DDO_W_BI      3'd2
`define DDO_W_BQ      3'd3
`define DDO_W_SA      3'd4
`define DDO_W_SB      3'd5
`endif

/* File: rtl/ddo_pkg.sv */
// Types for the sample output port: serializer states and module state.
// Assumes ddo_defs.svh is on the include path.
`include "ddo_defs.svh"
package ddo_pkg;
  typedef enum logic {DDO_IDLE, DDO_SHIFT} ddo_ser_e;

  typedef struct packed {
    logic c1, c2, c3;
    logic [2:0] p1, p2;
    logic [15:0] sh_a, sh_b;
    logic [4:0] cnt;
    logic [15:0] word_a, word_b;
    logic done;
  } ddo_rx_s;

  typedef struct packed {
    logic [`DDO_CTRL_W-1:0] ctrl;
    logic [7:0] div;
    logic [`DDO_EV_W-1:0] stat, mask;
    logic ack;
    logic [31:0] rdata;
    logic sync1, sync2, pen1, pen2;
    logic [2:0] sel1, sel2;
    logic [7:0][15:0] words;
    ddo_ser_e st;
    logic [31:0] sh_a, sh_b;
    logic [5:0] bitcnt;
    logic [7:0] divcnt;
    logic sck_int, out_a, out_b, fs;
    logic [3:0] dbgcnt;
    logic dbgclk;
    logic pin_a, pin_b, pin_fs, pin_ck, pin_rdy, pout_oe, dp_sync;
    logic [15:0] pout;
  } ddo_main_s;
endpackage : ddo_pkg

/* File: rtl/ddo_chain_rx.sv */
// Daisy-chain receiver: captures slave serial words from pins.
// Assumes chain clock and slave pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "ddo_defs.svh"
module ddo_chain_rx (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        chain_enable,
  input  wire logic        slave_edge_pol,
  input  wire logic        chain_clk_in,
  input  wire logic [2:0]  slave_pins,
  output logic      [15:0] word_a,
  output logic      [15:0] word_b,
  output logic             word_done
);
  import ddo_pkg::*;

  ddo_rx_s   r_q;
  ddo_rx_s   r_d;
  logic      cap;
  logic [15:0] na;
  logic [15:0] nb;
  logic [4:0]  nc;

  always_comb
  begin
    r_d = r_q;
    na  = r_q.sh_a;
    nb  = r_q.sh_b;
    nc  = r_q.cnt;
    // Data pins take two flops, one fewer than the clock pin, so bits line up with the edge seen at c2
    r_d.c1 = chain_clk_in;
    r_d.c2 = r_q.c1;
    r_d.c3 = r_q.c2;
    r_d.p1 = slave_pins;
    r_d.p2 = r_q.p1;
    r_d.done = 1'b0;
    cap = chain_enable & (slave_edge_pol ? (~r_q.c3 & r_q.c2)
                                         : (r_q.c3 & ~r_q.c2));
    if (cap)
    begin
      // Pin 2 frame, pin 1 channel B, pin 0 channel A
      if (r_q.p2[2])
      begin
        na = {15'h0000, r_q.p2[0]};
        nb = {15'h0000, r_q.p2[1]};
        nc = 5'd1;
      end
      else
      begin
        na = {r_q.sh_a[14:0], r_q.p2[0]};
        nb = {r_q.sh_b[14:0], r_q.p2[1]};
        nc = r_q.cnt + 5'd1;
      end
      if (nc == `DDO_RX_BITS)
      begin
        r_d.word_a = na;
        r_d.word_b = nb;
        r_d.done   = 1'b1;
        nc         = 5'd0;
      end
      r_d.sh_a = na;
      r_d.sh_b = nb;
      r_d.cnt  = nc;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign word_a    = r_q.word_a;
  assign word_b    = r_q.word_b;
  assign word_done = r_q.done;

  rx_count_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !cap |=> $stable(r_q.cnt))
    else $error("chain bit count moved without a capture edge");
endmodule : ddo_chain_rx
`default_nettype wire

/* File: rtl/ddo_out_port.sv */
// Output port of a two-channel downconverter: serial, parallel, ready.
// Assumes one clk; samples and debug tap come from logic on clk.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ddo_defs.svh"
module ddo_out_port (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  av_address,
  input  wire logic        av_read,
  input  wire logic        av_write,
  input  wire logic [31:0] av_writedata,
  output logic      [31:0] av_readdata,
  output logic             av_waitrequest,
  input  wire logic        sample_strobe,
  input  wire logic [15:0] sample_a_i,
  input  wire logic [15:0] sample_a_q,
  input  wire logic [15:0] sample_b_i,
  input  wire logic [15:0] sample_b_q,
  input  wire logic [19:0] debug_tap,
  input  wire logic        sync_n,
  input  wire logic        parallel_drive_enable_n,
  input  wire logic [2:0]  word_select,
  input  wire logic        chain_clk_in,
  output logic             serial_out_a,
  output logic             serial_out_a_oe,
  output logic             serial_out_b,
  output logic             serial_out_b_oe,
  output logic             serial_clk,
  output logic             serial_clk_oe,
  output logic             word_frame_strobe,
  output logic             word_frame_strobe_oe,
  output logic             ready_flag,
  output logic      [15:0] parallel_word_out,
  output logic             parallel_word_out_oe,
  output logic             datapath_sync,
  output logic             irq
);
  import ddo_pkg::*;

  ddo_main_s               q;
  ddo_main_s               n;
  logic                    wr;
  logic                    sync_act;
  logic                    osp_ok;
  logic                    launch;
  logic [7:0]              lim;
  logic [2:0]              psel;
  logic [`DDO_EV_W-1:0]    clr;
  logic [`DDO_EV_W-1:0]    ev;
  logic [15:0]             rx_a;
  logic [15:0]             rx_b;
  logic                    rx_done;

  function automatic logic [31:0] ddo_rd_mux(input logic [4:0] a, input ddo_main_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `DDO_OFF_CTRL)
      v[`DDO_CTRL_W-1:0] = s.ctrl;
    else if (a == `DDO_OFF_DIV)
      v[7:0] = s.div;
    else if (a == `DDO_OFF_STAT)
      v[`DDO_EV_W-1:0] = s.stat;
    else if (a == `DDO_OFF_MASK)
      v[`DDO_EV_W-1:0] = s.mask;
    else if (a == `DDO_OFF_INFO)
      v[9:0] = {s.pen2, ~s.sync2, s.st == DDO_SHIFT, 1'b0, s.bitcnt};
    return v;
  endfunction : ddo_rd_mux

  // Slave pins arrive on word_select while this part is chain master
  ddo_chain_rx u_chain (
    .clk            (clk),
    .reset_n        (reset_n),
    .chain_enable   (q.ctrl[`DDO_C_CM]),
    .slave_edge_pol (q.ctrl[`DDO_C_SLVP]),
    .chain_clk_in   (chain_clk_in),
    .slave_pins     (word_select),
    .word_a         (rx_a),
    .word_b         (rx_b),
    .word_done      (rx_done)
  );

  always_comb
  begin
    n        = q;
    clr      = '0;
    launch   = 1'b0;
    wr       = av_write & q.ack;
    // One wait cycle on every access; reads are latched in the first
    n.ack    = (av_read | av_write) & ~q.ack;
    if (av_read & ~q.ack)
      n.rdata = ddo_rd_mux(av_address, q);
    if (wr)
    begin
      if (av_address == `DDO_OFF_CTRL)
        n.ctrl = av_writedata[`DDO_CTRL_W-1:0];
      else if (av_address == `DDO_OFF_DIV)
        n.div = av_writedata[7:0];
      else if (av_address == `DDO_OFF_STAT)
        clr = av_writedata[`DDO_EV_W-1:0];
      else if (av_address == `DDO_OFF_MASK)
        n.mask = av_writedata[`DDO_EV_W-1:0];
    end
    n.sync1  = sync_n;
    n.sync2  = q.sync1;
    n.pen1   = parallel_drive_enable_n;
    n.pen2   = q.pen1;
    n.sel1   = word_select;
    n.sel2   = q.sel1;
    sync_act = ~q.sync2;
    osp_ok   = sample_strobe & ~sync_act;
    lim      = (q.div == 8'h00) ? 8'h00 : q.div - 8'h01;
    n.dp_sync = sync_act;
    if (sync_act)
    begin
      // Flush serializer state, shift registers and held words; the serial stream restarts on a new sample
      n.st      = DDO_IDLE;
      n.sck_int = 1'b0;
      n.bitcnt  = 6'd0;
      n.fs      = 1'b0;
      n.sh_a    = 32'h0000_0000;
      n.sh_b    = 32'h0000_0000;
      for (int i = 0; i <= 5; i++)
        n.words[i] = 16'h0000;
    end
    else
    begin
      if (sample_strobe)
      begin
        n.words[`DDO_W_AI] = sample_a_i;
        n.words[`DDO_W_AQ] = sample_a_q;
        n.words[`DDO_W_BI] = sample_b_i;
        n.words[`DDO_W_BQ] = sample_b_q;
      end
      case (q.st)
        DDO_IDLE:
        begin
          if (sample_strobe)
          begin
            n.sh_a    = {sample_a_i, sample_a_q};
            n.sh_b    = {sample_b_i, sample_b_q};
            n.st      = DDO_SHIFT;
            n.sck_int = 1'b0;
            n.divcnt  = 8'h00;
            n.bitcnt  = 6'd0;
          end
        end
        DDO_SHIFT:
        begin
          if (q.divcnt == lim)
          begin
            n.divcnt  = 8'h00;
            n.sck_int = ~q.sck_int;
            launch    = ~q.sck_int;
          end
          else
            n.divcnt = q.divcnt + 8'h01;
        end
        default: n.st = DDO_IDLE;
      endcase
      if (launch)
      begin
        if (q.bitcnt == `DDO_SER_BITS)
        begin
          n.st      = DDO_IDLE;
          n.sck_int = 1'b0;
          n.fs      = 1'b0;
        end
        else
        begin
          n.out_a  = q.sh_a[31];
          n.out_b  = q.sh_b[31];
          n.sh_a   = {q.sh_a[30:0], 1'b0};
          n.sh_b   = {q.sh_b[30:0], 1'b0};
          n.fs     = (q.bitcnt == 6'd0) | (~q.ctrl[`DDO_C_PACK] &
                     (q.bitcnt == `DDO_HALF_BITS));
          n.bitcnt = q.bitcnt + 6'd1;
        end
      end
      if (rx_done)
      begin
        n.words[`DDO_W_SA] = rx_a;
        n.words[`DDO_W_SB] = rx_b;
      end
    end
    // Debug clock: rate 0 toggles every cycle, the fastest the pin can follow
    if (q.dbgcnt >= q.ctrl[`DDO_C_RATE])
    begin
      n.dbgcnt = 4'h0;
      n.dbgclk = ~q.dbgclk;
    end
    else
      n.dbgcnt = q.dbgcnt + 4'h1;
    ev = '0;
    ev[`DDO_S_OSP]   = osp_ok;
    ev[`DDO_S_OVR]   = osp_ok & (q.st == DDO_SHIFT);
    ev[`DDO_S_FLUSH] = sync_act;
    ev[`DDO_S_CHAIN] = rx_done;
    // Set wins over a clear in the same cycle
    n.stat = (q.stat & ~clr) | ev;
    psel = n.ctrl[`DDO_C_CM] ? n.ctrl[`DDO_C_CSEL] : q.sel2;
    if (n.ctrl[`DDO_C_DBG])
    begin
      n.pin_a   = debug_tap[1];
      n.pin_b   = debug_tap[0];
      n.pin_fs  = debug_tap[2];
      n.pin_rdy = debug_tap[3];
      n.pout    = debug_tap[19:4];
      n.pin_ck  = n.dbgclk;
      n.pout_oe = 1'b1;
    end
    else
    begin
      n.pin_a   = n.out_a;
      n.pin_b   = n.out_b;
      n.pin_fs  = n.fs ^ n.ctrl[`DDO_C_FSP];
      n.pin_rdy = osp_ok ^ n.ctrl[`DDO_C_RDYP];
      n.pout    = n.words[psel];
      n.pin_ck  = n.sck_int ^ n.ctrl[`DDO_C_SCKP];
      n.pout_oe = ~q.pen2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      q       <= '0;
      q.ctrl  <= `DDO_CTRL_RST;
      q.div   <= `DDO_DIV_RST;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.pen1  <= 1'b1;
      q.pen2  <= 1'b1;
    end
    else
      q <= n;
  end

  assign av_readdata          = q.rdata;
  assign av_waitrequest       = (av_read | av_write) & ~q.ack;
  assign serial_out_a         = q.pin_a;
  assign serial_out_b         = q.pin_b;
  assign serial_clk           = q.pin_ck;
  assign word_frame_strobe    = q.pin_fs;
  // Released only by software so a shared line is never fought at power up
  assign serial_out_a_oe      = q.ctrl[`DDO_C_SOE];
  assign serial_out_b_oe      = q.ctrl[`DDO_C_SOE];
  assign serial_clk_oe        = q.ctrl[`DDO_C_SOE];
  assign word_frame_strobe_oe = q.ctrl[`DDO_C_SOE];
  assign ready_flag           = q.pin_rdy;
  assign parallel_word_out    = q.pout;
  assign parallel_word_out_oe = q.pout_oe;
  assign datapath_sync        = q.dp_sync;
  assign irq                  = |(q.stat & q.mask);

  msb_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    launch && q.bitcnt < `DDO_SER_BITS |=> q.ctrl[`DDO_C_DBG] || serial_out_a == $past(q.sh_a[31]))
    else $error("serial bit is not the word msb");
  launch_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(serial_out_a) && !q.ctrl[`DDO_C_DBG] && $past(!q.ctrl[`DDO_C_DBG])
      && $stable(q.ctrl[`DDO_C_SCKP])
      |-> $changed(serial_clk) && serial_clk == !q.ctrl[`DDO_C_SCKP])
    else $error("serial data changed off the launch edge");
  serial_release_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr && av_address == `DDO_OFF_CTRL && !av_writedata[`DDO_C_SOE]
      |=> !serial_clk_oe && !serial_out_a_oe && !word_frame_strobe_oe)
    else $error("serial pins driven while disabled");
  frame_start_a: assert property (@(posedge clk) disable iff (!reset_n)
    launch && q.bitcnt == 6'd0 |=> q.ctrl[`DDO_C_DBG] || word_frame_strobe == !q.ctrl[`DDO_C_FSP])
    else $error("frame strobe missing at word start");
  packed_mid_a: assert property (@(posedge clk) disable iff (!reset_n)
    launch && q.bitcnt == `DDO_HALF_BITS && q.ctrl[`DDO_C_PACK]
      |=> q.ctrl[`DDO_C_DBG] || word_frame_strobe == q.ctrl[`DDO_C_FSP])
    else $error("frame strobe inside packed pair");
  debug_route_a: assert property (@(posedge clk) disable iff (!reset_n)
    q.ctrl[`DDO_C_DBG] |-> serial_out_a == $past(debug_tap[1])
      && serial_out_b == $past(debug_tap[0]) && word_frame_strobe == $past(debug_tap[2])
      && ready_flag == $past(debug_tap[3]) && parallel_word_out == $past(debug_tap[19:4]))
    else $error("debug tap routed wrongly");
  debug_clock_a: assert property (@(posedge clk) disable iff (!reset_n)
    q.ctrl[`DDO_C_DBG] && $past(q.ctrl[`DDO_C_DBG]) && q.ctrl[`DDO_C_RATE] == 4'h0
      && $past(q.ctrl[`DDO_C_RATE]) == 4'h0 |-> serial_clk != $past(serial_clk))
    else $error("debug clock does not follow input clock");
  word_pick_a: assert property (@(posedge clk) disable iff (!reset_n)
    !q.ctrl[`DDO_C_DBG] && !q.ctrl[`DDO_C_CM] |-> parallel_word_out == q.words[$past(q.sel2)])
    else $error("parallel word does not match select");
  par_enable_a: assert property (@(posedge clk) disable iff (!reset_n)
    !q.ctrl[`DDO_C_DBG] |-> parallel_word_out_oe == !$past(q.pen2))
    else $error("parallel drive ignores enable");
  ready_mark_a: assert property (@(posedge clk) disable iff (!reset_n)
    osp_ok |=> q.ctrl[`DDO_C_DBG] || ready_flag == !q.ctrl[`DDO_C_RDYP])
    else $error("ready flag missed a sample period");
  sync_flush_a: assert property (@(posedge clk) disable iff (!reset_n)
    sync_act |=> q.st == DDO_IDLE && q.words[`DDO_W_AI] == 16'h0000 && datapath_sync)
    else $error("sync did not flush the datapath");
  reset_ctrl_a: assert property (@(posedge clk)
    !reset_n |=> q.ctrl == `DDO_CTRL_RST && q.div == `DDO_DIV_RST && q.mask == '0)
    else $error("control registers not at reset value");
endmodule : ddo_out_port
`default_nettype wire

/* File: tb/ddo_slave_model.sv */
// Daisy-chain slave model: sends one A/B word pair per rising go.
// Assumes the master samples these pins with its own faster clock.
`timescale 1ns/1ps
`default_nettype none
module ddo_slave_model (
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic        edge_pol,
  input  wire logic [15:0] data_a,
  input  wire logic [15:0] data_b,
  output logic             chain_clk,
  output logic      [2:0]  pins,
  output logic             busy
);
  int half;
  initial
  begin
    chain_clk = 1'b0;
    pins = 3'h0;
    busy = 1'b0;
  end
  // Clock stands still between words, at the idle level of its polarity
  always @(posedge go)
  begin
    // Chain clock period stays 64 ns; slow only stretches the lead-in
    half = 32;
    busy = 1'b1;
    pins = 3'h0;
    chain_clk = edge_pol;
    #(slow ? 3 * half : half);
    for (int i = 15; i >= 0; i--)
    begin
      pins = {i == 15, data_b[i], data_a[i]};
      chain_clk = !edge_pol;
      #(half);
      chain_clk = edge_pol;
      #(half);
    end
    // Released lines must not keep the last bit
    pins = ~pins;
    busy = 1'b0;
  end
endmodule : ddo_slave_model
`default_nettype wire

/* File: tb/ddo_out_port_bench.sv */
// Testbench for the sample output port: bus tasks, serial sampler, tests.
// Assumes the slave model stands in for a chain slave on the select pins.
`timescale 1ns/1ps
`default_nettype none
`include "ddo_defs.svh"
module ddo_out_port_bench;
  localparam logic [63:0] S1 = 64'h8001_7ffe_c3a5_0f0f;
  localparam logic [63:0] S2 = 64'hfffe_0001_8000_7fff;
  logic        clk = 1'b0, reset_n = 1'b0, av_read = 1'b0, av_write = 1'b0;
  logic [4:0]  av_address = 5'h00;
  logic [31:0] av_writedata = 32'h0, av_readdata, got_a, got_b, got_fs, q;
  logic        av_waitrequest, sample_strobe = 1'b0, sync_n = 1'b1;
  logic [15:0] sample_a_i = 16'h0, sample_a_q = 16'h0, sample_b_i = 16'h0;
  logic [15:0] sample_b_q = 16'h0, parallel_word_out, da = 16'h0, db = 16'h0;
  logic [19:0] debug_tap = 20'h0;
  logic        serial_out_a, serial_out_a_oe, serial_out_b, serial_out_b_oe, serial_clk;
  logic        serial_clk_oe, word_frame_strobe, word_frame_strobe_oe, ready_flag;
  logic        parallel_word_out_oe, datapath_sync, irq, chain_clk_in, busy;
  logic        parallel_drive_enable_n = 1'b1, use_slave = 1'b0, go = 1'b0, slow = 1'b0;
  logic        spol = 1'b0, sckp = 1'b0, fpol = 1'b0, rpol = 1'b0, watch = 1'b0;
  logic        pa, pb, pf, pk;
  logic [2:0]  word_select, sel_pin = 3'h0, slave_pins;
  int          failures = 0, num_checks = 0, nbits = 0, bad_edge = 0, n;

  assign word_select = use_slave ? slave_pins : sel_pin;
  always #4 clk = ~clk;

  ddo_out_port u_ddo_out_port (
    .clk, .reset_n, .av_address, .av_read, .av_write, .av_writedata, .av_readdata,
    .av_waitrequest, .sample_strobe, .sample_a_i, .sample_a_q, .sample_b_i, .sample_b_q,
    .debug_tap, .sync_n, .parallel_drive_enable_n, .word_select, .chain_clk_in,
    .serial_out_a, .serial_out_a_oe, .serial_out_b, .serial_out_b_oe, .serial_clk,
    .serial_clk_oe, .word_frame_strobe, .word_frame_strobe_oe, .ready_flag,
    .parallel_word_out, .parallel_word_out_oe, .datapath_sync, .irq
  );

  ddo_slave_model u_ddo_slave_model (
    .go, .slow, .edge_pol(spol), .data_a(da), .data_b(db), .chain_clk(chain_clk_in),
    .pins(slave_pins), .busy
  );

  // Serial sampler: takes bits on the capture edge, counts changes off launch edges
  always @(negedge clk)
  begin
    if (watch && pk !== serial_clk && serial_clk === sckp && nbits < 32)
    begin
      got_a = {got_a[30:0], serial_out_a};
      got_b = {got_b[30:0], serial_out_b};
      got_fs = {got_fs[30:0], word_frame_strobe ^ fpol};
      nbits++;
    end
    if (watch && {pa, pb, pf} !== {serial_out_a, serial_out_b, word_frame_strobe}
        && !(pk === sckp && serial_clk === !sckp))
      bad_edge++;
    {pa, pb, pf, pk} = {serial_out_a, serial_out_b, word_frame_strobe, serial_clk};
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Every task that waits on clk starts on a rising edge and ends on a falling one
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    av_address <= a;
    av_writedata <= d;
    av_write <= wr;
    av_read <= !wr;
    n = 0;
    // Read right after the edge: these are the values the slave sampled there
    do
    begin
      @(posedge clk);
      n++;
    end
    while (av_waitrequest !== 1'b0 && n < 20);
    if (av_waitrequest !== 1'b0) tally_and_finish(1'b1);
    q = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
    @(negedge clk);
  endtask : xfer

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(q & m, e);
  endtask : rdc

  task automatic strobe(input logic [63:0] s);
    @(posedge clk);
    {sample_a_i, sample_a_q, sample_b_i, sample_b_q} <= s;
    sample_strobe <= 1'b1;
    @(posedge clk);
    sample_strobe <= 1'b0;
    @(negedge clk);
    check(ready_flag, !rpol);
  endtask : strobe

  task automatic wait_idle();
    for (int i = 0; i < 200; i++)
    begin
      xfer(1'b0, `DDO_OFF_INFO, 32'h0);
      if (q[7] === 1'b0) return;
    end
    tally_and_finish(1'b1);
  endtask : wait_idle

  task automatic frame(input logic [63:0] s, input logic [31:0] efs);
    wait_idle();
    nbits = 0;
    bad_edge = 0;
    watch = 1'b1;
    strobe(s);
    for (n = 0; n < 400 && nbits < 32; n++) @(negedge clk);
    if (nbits < 32) tally_and_finish(1'b1);
    watch = 1'b0;
    check(got_a, s[63:32]);
    check(got_b, s[31:0]);
    check(got_fs, efs);
    check(bad_edge, 32'h0);
  endtask : frame

  task automatic chain(input logic p, input logic sl, input logic [15:0] a,
                       input logic [15:0] b);
    wr(`DDO_OFF_CTRL, {17'h0, 3'h4, 4'h0, p, 7'h40});
    wr(`DDO_OFF_STAT, 32'hf);
    @(posedge clk);
    {spol, slow, da, db, go, use_slave, parallel_drive_enable_n} <= {p, sl, a, b, 3'b110};
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 600 && busy !== 1'b0; n++) @(negedge clk);
    if (busy !== 1'b0) tally_and_finish(1'b1);
    repeat (8) @(negedge clk);
    rdc(`DDO_OFF_STAT, 32'h8, 32'h8);
    check(parallel_word_out, a);
    wr(`DDO_OFF_CTRL, {17'h0, 3'h5, 4'h0, p, 7'h40});
    repeat (4) @(negedge clk);
    check(parallel_word_out, b);
  endtask : chain

  task automatic tally_and_finish(input logic hung);
    if (hung) failures++;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    logic [127:0] tbl;
    logic [19:0]  v;
    logic         k;
    tbl = {S1, 16'h0ff0, 16'hf00f, 32'h0};
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check({serial_out_a_oe, serial_out_b_oe, serial_clk_oe, word_frame_strobe_oe}, 0);
    rdc(`DDO_OFF_CTRL, 32'hffffffff, 32'h0);
    rdc(`DDO_OFF_DIV, 32'hffffffff, 32'h4);
    rdc(`DDO_OFF_MASK, 32'hffffffff, 32'h0);
    wr(5'h14, 32'hffffffff);
    rdc(5'h14, 32'hffffffff, 32'h0);
    $display("reset test done");
    strobe(S1);
    rdc(`DDO_OFF_STAT, 32'h1, 32'h1);
    check(irq, 1'b0);
    wr(`DDO_OFF_MASK, 32'h1);
    check(irq, 1'b1);
    wr(`DDO_OFF_STAT, 32'h1);
    check(irq, 1'b0);
    wr(`DDO_OFF_CTRL, 32'h8);
    rpol = 1'b1;
    strobe(S2);
    // One cycle later the pulse is over and the flag rests high
    @(negedge clk);
    check(ready_flag, 1'b1);
    $display("ready test done");
    wr(`DDO_OFF_DIV, 32'h1);
    wr(`DDO_OFF_CTRL, 32'h9);
    check({serial_out_a_oe, serial_out_b_oe, serial_clk_oe, word_frame_strobe_oe}, 4'hf);
    frame(S1, 32'h80008000);
    wr(`DDO_OFF_CTRL, 32'h1f);
    {sckp, fpol} = 2'b11;
    frame(S2, 32'h80000000);
    $display("serial test done");
    chain(1'b0, 1'b0, 16'h9c31, 16'h63ce);
    chain(1'b1, 1'b1, 16'h0ff0, 16'hf00f);
    $display("chain test done");
    wr(`DDO_OFF_CTRL, 32'h0);
    @(posedge clk);
    {use_slave, parallel_drive_enable_n, rpol} <= 3'b010;
    strobe(S1);
    repeat (4) @(negedge clk);
    check(parallel_word_out_oe, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      {parallel_drive_enable_n, sel_pin} <= {1'b0, i[2:0]};
      repeat (4) @(negedge clk);
      check(parallel_word_out, tbl[127 - 16 * i -: 16]);
    end
    check(parallel_word_out_oe, 1'b1);
    $display("parallel test done");
    @(posedge clk);
    {sync_n, sel_pin} <= 4'h0;
    // Two sync flops, then the registered flag
    repeat (4) @(negedge clk);
    check(datapath_sync, 1'b1);
    @(posedge clk);
    sync_n <= 1'b1;
    repeat (5) @(negedge clk);
    check({datapath_sync, parallel_word_out}, 0);
    rdc(`DDO_OFF_STAT, 32'h4, 32'h4);
    $display("sync test done");
    // Debug mode with select and enable pins set to values it must ignore
    wr(`DDO_OFF_CTRL, 32'h21);
    @(posedge clk);
    {parallel_drive_enable_n, sel_pin} <= 4'hf;
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 20'ha5a3c : 20'h5a5c3;
      @(posedge clk);
      debug_tap <= v;
      repeat (3) @(negedge clk);
      check({parallel_word_out, ready_flag, word_frame_strobe, serial_out_a, serial_out_b}, v);
      k = serial_clk;
      @(negedge clk);
      check(serial_clk, !k);
    end
    check(parallel_word_out_oe, 1'b1);
    $display("debug test done");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check({serial_out_a_oe, serial_clk_oe, parallel_word_out_oe}, 0);
    rdc(`DDO_OFF_CTRL, 32'hffffffff, 32'h0);
    rdc(`DDO_OFF_DIV, 32'hffffffff, 32'h4);
    $display("second reset test done");
    tally_and_finish(1'b0);
  end
endmodule : ddo_out_port_bench
`default_nettype wire
